/* scdc_pkg.sv */
/*
  Package for the synthesizer calibration and divider control block.
  Holds register offsets, field positions, reset values, sequencer states and
  the fixed counts of the calibration phases. Assumes a 32-bit APB register bus.
*/
package scdc_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_INT_VALUE  = 8'h00;
  localparam logic [7:0] REG_PRIM_FRAC  = 8'h04;
  localparam logic [7:0] REG_AUX_FRAC   = 8'h08;
  localparam logic [7:0] REG_REF_CFG    = 8'h0C;
  localparam logic [7:0] REG_TRIGGER    = 8'h10;
  localparam logic [7:0] REG_CAL_CFG    = 8'h14;
  localparam logic [7:0] REG_STATUS     = 8'h18;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int AUX_MOD_LSB     = 16;
  localparam int REF_DOUBLER_BIT = 7;
  localparam int REF_HALVE_BIT   = 8;
  localparam int REF_MODE_BIT    = 6;
  localparam int MOD_DIS_BIT     = 9;
  localparam int CAL_LVL_LSB     = 5;
  localparam int CAL_LOW_LSB     = 10;
  localparam int CAL_BDIV_LSB    = 20;
  localparam int CAL_AUTO_BIT    = 28;

  // ---------------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_INT_VALUE  = 16'h004B;
  localparam logic [13:0] RST_AUX_MOD    = 14'h0002;
  localparam logic [4:0]  RST_SETTLE_HI  = 5'h02;
  localparam logic [4:0]  RST_LEVEL_HI   = 5'h03;
  localparam logic [9:0]  RST_SETTLE_LO  = 10'h002;
  localparam logic [7:0]  RST_BAND_DIV   = 8'h01;
  localparam logic [4:0]  RST_REF_COUNT  = 5'h01;

  // ---------------------------------------------------------------------------
  // Calibration phase counts.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] BAND_CYC_LAST  = 4'hF;   // 16 band clocks per step.
  localparam logic [3:0] BAND_STEP_LAST = 4'hA;   // 11 band steps.
  localparam logic [5:0] LVL_STEP_LAST  = 6'h3E;  // 63 level steps.

  // Sequencer states.
  typedef enum logic [1:0] {
    SCDC_IDLE   = 2'b00,
    SCDC_SETTLE = 2'b01,
    SCDC_BAND   = 2'b10,
    SCDC_LEVEL  = 2'b11
  } scdc_state_t;

endpackage : scdc_pkg

/* scdc_top.sv */
/*
  Calibration sequencer and feedback/reference divider control of a
  fractional-N synthesizer, with an APB register slave.
  Assumes pclk is the phase-detector clock and that the APB master follows
  the usual setup/access protocol. Analog parts lie outside.
*/
// Operation
// - Settle, band select, level cal, loop settle.
// - Settle lasts high times 1024 plus low.
// - Settle expiry advances to band selection.
// - Band clock is phase clock over divider.
// - Band select: 11 steps of 16 clocks.
// - Level cal: 63 steps of high*1024+low.
// - Bit 6 selects differential reference input.
// - Ratio is int plus fractions over 2^25.
// - Zero fractions: integer mode; only bit 9 turns modulators off.
// - Reference counter divides 1..32, doubler, halving.
// - Trigger write starts calibration when enabled.
// - Buffered settings apply on trigger write.
`timescale 1ns/1ps

module scdc_top (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Active divider settings.
  output logic      [15:0] int_value,
  output logic      [24:0] primary_fraction,
  output logic      [13:0] auxiliary_fraction,
  output logic      [13:0] auxiliary_modulus,
  output logic             fractional_mode,
  output logic             modulator_disable,
  // Reference path.
  output logic      [5:0]  ref_divide_ratio,
  output logic             ref_doubler,
  output logic             ref_halve,
  output logic             ref_differential,
  // Calibration.
  output logic             tune_hold,
  output logic             band_tick,
  output logic      [1:0]  cal_phase
);

  // ---------------------------------------------------------------------------
  // State record.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    scdc_pkg::scdc_state_t st;
    logic [14:0] timer;
    logic [7:0]  bdiv;
    logic [3:0]  bcyc;
    logic [5:0]  step;
    logic [15:0] int_val;
    logic [24:0] primary_fraction_s;
    logic [13:0] auxiliary_fraction_s;
    logic [13:0] auxiliary_modulus_s;
    logic [4:0]  rcnt_s;
    logic        dbl_s;
    logic        half_s;
    logic [24:0] primary_fraction_a;
    logic [13:0] auxiliary_fraction_a;
    logic [13:0] auxiliary_modulus_a;
    logic [5:0]  rdiv_a;
    logic        dbl_a;
    logic        half_a;
    logic        fracmode_a;
    logic        ref_mode;
    logic        mod_dis;
    logic [4:0]  settle_hi;
    logic [4:0]  level_hi;
    logic [9:0]  settle_lo;
    logic [7:0]  band_div;
    logic        auto_en;
    logic        hold;
    logic        tick;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } scdc_regs_t;

  scdc_regs_t q;
  scdc_regs_t d;

  logic        acc;
  logic        wr;
  logic        trig;
  logic [14:0] settle_load;
  logic [14:0] level_load;
  logic [8:0]  bdiv_next;

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------

  // The settle phase and each level step last the high count in units of 1024 plus the shared low count;
  // the low count never exceeds ten bits, so concatenation is the exact sum.
  assign settle_load = {q.settle_hi, q.settle_lo};
  assign level_load  = {q.level_hi, q.settle_lo};
  assign bdiv_next   = {1'b0, q.bdiv} + 9'h001;

  always_comb begin
    d        = q;
    d.ready  = 1'b0;
    d.slverr = 1'b0;
    d.tick   = 1'b0;
    // One wait state lets read data come straight from a flop.
    acc  = psel & penable & ~q.ready;
    wr   = psel & penable & q.ready & pwrite;
    trig = 1'b0;

    // Answer phase: read data and error are prepared one cycle ahead.
    if (acc) begin
      d.ready = 1'b1;
      d.rdata = 32'h0000_0000;
      case (paddr)
        scdc_pkg::REG_INT_VALUE: d.rdata[15:0] = q.int_val;
        scdc_pkg::REG_PRIM_FRAC: d.rdata[24:0] = q.primary_fraction_s;
        scdc_pkg::REG_AUX_FRAC: begin
          d.rdata[13:0] = q.auxiliary_fraction_s;
          d.rdata[scdc_pkg::AUX_MOD_LSB +: 14] = q.auxiliary_modulus_s;
        end
        scdc_pkg::REG_REF_CFG: begin
          d.rdata[4:0] = q.rcnt_s;
          d.rdata[scdc_pkg::REF_MODE_BIT] = q.ref_mode;
          d.rdata[scdc_pkg::REF_DOUBLER_BIT] = q.dbl_s;
          d.rdata[scdc_pkg::REF_HALVE_BIT] = q.half_s;
          d.rdata[scdc_pkg::MOD_DIS_BIT] = q.mod_dis;
        end
        scdc_pkg::REG_TRIGGER: d.rdata = 32'h0000_0000;
        scdc_pkg::REG_CAL_CFG: begin
          d.rdata[4:0] = q.settle_hi;
          d.rdata[scdc_pkg::CAL_LVL_LSB +: 5] = q.level_hi;
          d.rdata[scdc_pkg::CAL_LOW_LSB +: 10] = q.settle_lo;
          d.rdata[scdc_pkg::CAL_BDIV_LSB +: 8] = q.band_div;
          d.rdata[scdc_pkg::CAL_AUTO_BIT] = q.auto_en;
        end
        scdc_pkg::REG_STATUS: begin
          d.rdata[1:0]   = q.st;
          d.rdata[2]     = q.hold;
          d.rdata[3]     = q.fracmode_a;
          d.rdata[11:8]  = q.bcyc;
          d.rdata[21:16] = q.step;
        end
        default: d.slverr = 1'b1;
      endcase
    end

    // Writes take effect at the edge where pready is seen high.
    if (wr) begin
      case (paddr)
        scdc_pkg::REG_INT_VALUE: d.int_val = pwdata[15:0];
        scdc_pkg::REG_PRIM_FRAC: d.primary_fraction_s = pwdata[24:0];
        scdc_pkg::REG_AUX_FRAC: begin
          d.auxiliary_fraction_s = pwdata[13:0];
          d.auxiliary_modulus_s  = pwdata[scdc_pkg::AUX_MOD_LSB +: 14];
        end
        scdc_pkg::REG_REF_CFG: begin
          d.rcnt_s   = pwdata[4:0];
          d.ref_mode = pwdata[scdc_pkg::REF_MODE_BIT];
          d.dbl_s    = pwdata[scdc_pkg::REF_DOUBLER_BIT];
          d.half_s   = pwdata[scdc_pkg::REF_HALVE_BIT];
          d.mod_dis  = pwdata[scdc_pkg::MOD_DIS_BIT];
        end
        scdc_pkg::REG_TRIGGER: trig = 1'b1;
        scdc_pkg::REG_CAL_CFG: begin
          d.settle_hi = pwdata[4:0];
          d.level_hi  = pwdata[scdc_pkg::CAL_LVL_LSB +: 5];
          d.settle_lo = pwdata[scdc_pkg::CAL_LOW_LSB +: 10];
          d.band_div  = pwdata[scdc_pkg::CAL_BDIV_LSB +: 8];
          d.auto_en   = pwdata[scdc_pkg::CAL_AUTO_BIT];
        end
        default: trig = 1'b0;
      endcase
    end

    // Calibration sequencer; idle is the loop-settling phase.
    case (q.st)
      scdc_pkg::SCDC_IDLE: begin
        d.hold = 1'b0;
      end
      scdc_pkg::SCDC_SETTLE: begin
        if (q.timer <= 15'h0001) begin
          d.st   = scdc_pkg::SCDC_BAND;
          d.bdiv = 8'h00;
          d.bcyc = 4'h0;
          d.step = 6'h00;
        end else begin
          d.timer = q.timer - 15'h0001;
        end
      end
      scdc_pkg::SCDC_BAND: begin
        // A divider of zero behaves like one so the phase cannot hang.
        if (bdiv_next >= {1'b0, q.band_div}) begin
          d.bdiv = 8'h00;
          d.tick = 1'b1;
          d.bcyc = q.bcyc + 4'h1;
          if (q.bcyc == scdc_pkg::BAND_CYC_LAST) begin
            if (q.step[3:0] == scdc_pkg::BAND_STEP_LAST) begin
              d.st    = scdc_pkg::SCDC_LEVEL;
              d.step  = 6'h00;
              d.timer = level_load;
            end else begin
              d.step = q.step + 6'h01;
            end
          end
        end else begin
          d.bdiv = bdiv_next[7:0];
        end
      end
      scdc_pkg::SCDC_LEVEL: begin
        if (q.timer <= 15'h0001) begin
          if (q.step == scdc_pkg::LVL_STEP_LAST) begin
            d.st   = scdc_pkg::SCDC_IDLE;
            d.hold = 1'b0;
            d.step = 6'h00;
          end else begin
            d.step  = q.step + 6'h01;
            d.timer = level_load;
          end
        end else begin
          d.timer = q.timer - 15'h0001;
        end
      end
      default: d.st = scdc_pkg::SCDC_IDLE;
    endcase

    // A trigger write loads buffered settings and, with automatic start on, restarts calibration,
    // even mid-sequence, since the old band choice no longer applies.
    if (trig) begin
      d.primary_fraction_a    = q.primary_fraction_s;
      d.auxiliary_fraction_a    = q.auxiliary_fraction_s;
      d.auxiliary_modulus_a     = q.auxiliary_modulus_s;
      d.dbl_a      = q.dbl_s;
      d.half_a     = q.half_s;
      d.rdiv_a     = (q.rcnt_s == 5'h00) ? 6'h20 : {1'b0, q.rcnt_s};
      d.fracmode_a = (q.primary_fraction_s != 25'h0) | (q.auxiliary_fraction_s != 14'h0);
      if (q.auto_en) begin
        d.st    = scdc_pkg::SCDC_SETTLE;
        d.timer = settle_load;
        d.hold  = 1'b1;
        d.bdiv  = 8'h00;
        d.bcyc  = 4'h0;
        d.step  = 6'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.st        <= scdc_pkg::SCDC_IDLE;
      q.int_val   <= scdc_pkg::RST_INT_VALUE;
      q.auxiliary_modulus_s    <= scdc_pkg::RST_AUX_MOD;
      q.auxiliary_modulus_a    <= scdc_pkg::RST_AUX_MOD;
      q.rcnt_s    <= scdc_pkg::RST_REF_COUNT;
      q.rdiv_a    <= {1'b0, scdc_pkg::RST_REF_COUNT};
      q.settle_hi <= scdc_pkg::RST_SETTLE_HI;
      q.level_hi  <= scdc_pkg::RST_LEVEL_HI;
      q.settle_lo <= scdc_pkg::RST_SETTLE_LO;
      q.band_div  <= scdc_pkg::RST_BAND_DIV;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from the state register.
  // ---------------------------------------------------------------------------

  // The divide ratio is int + (primary_fraction + auxiliary_fraction/auxiliary_modulus) / 2^25, applied downstream.
  assign int_value          = q.int_val;
  assign primary_fraction   = q.primary_fraction_a;
  assign auxiliary_fraction = q.auxiliary_fraction_a;
  assign auxiliary_modulus  = q.auxiliary_modulus_a;
  assign fractional_mode    = q.fracmode_a;
  assign modulator_disable  = q.mod_dis;
  assign ref_divide_ratio   = q.rdiv_a;
  assign ref_doubler        = q.dbl_a;
  assign ref_halve          = q.half_a;
  assign ref_differential   = q.ref_mode;
  assign tune_hold          = q.hold;
  assign band_tick          = q.tick;
  assign cal_phase          = q.st;
  assign prdata             = q.rdata;
  assign pready             = q.ready;
  assign pslverr            = q.slverr;

endmodule : scdc_top

/* scdc_chk.sv */
/*
  Checker for scdc_top: phase order and lengths, trigger start, loads.
  Assumes a one-wait-state APB slave on pclk.
*/
`timescale 1ns/1ps
module scdc_chk (
  // Clock, reset and APB.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Outputs watched.
  input wire logic [15:0] int_value,
  input wire logic [24:0] primary_fraction,
  input wire logic [13:0] auxiliary_fraction,
  input wire logic        fractional_mode,
  input wire logic [5:0]  ref_divide_ratio,
  input wire logic        ref_differential,
  input wire logic        tune_hold,
  input wire logic        band_tick,
  input wire logic [1:0]  cal_phase
);
  // ---------------------------------------------------------------------------
  // Mirror of the calibration word and a phase length counter.
  // ---------------------------------------------------------------------------
  logic        wr_done;
  logic [31:0] cfg_q;
  logic [1:0]  ph_q;
  logic [31:0] cnt_q;
  logic [31:0] lo;
  assign wr_done = psel & penable & pwrite & pready;
  assign lo = 32'(cfg_q[19:10]);
  // The block hides its settings, so they are mirrored as they are written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 32'h0;
      ph_q  <= 2'h0;
      cnt_q <= 32'h0;
    end else begin
      if (wr_done && paddr == scdc_pkg::REG_CAL_CFG) cfg_q <= pwdata;
      ph_q  <= cal_phase;
      cnt_q <= (cal_phase != ph_q) ? 32'h1 : cnt_q + 32'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_order;
    (cal_phase != ph_q) |-> cal_phase == 2'h1 || cal_phase == ph_q + 2'h1;
  endproperty
  a_order: assert property (p_order) else $error("phase out of order");
  property p_start;
    wr_done && paddr == scdc_pkg::REG_TRIGGER && cfg_q[28] |-> ##[1:2]
      cal_phase == scdc_pkg::SCDC_SETTLE && tune_hold;
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start");
  property p_hold;
    tune_hold == (cal_phase != scdc_pkg::SCDC_IDLE);
  endproperty
  a_hold: assert property (p_hold) else $error("hold not tied to phase");
  property p_settle;
    (cal_phase == scdc_pkg::SCDC_BAND && ph_q == scdc_pkg::SCDC_SETTLE) |->
      cnt_q == 32'(cfg_q[4:0]) * 32'd1024 + lo;
  endproperty
  a_settle: assert property (p_settle) else $error("settle length wrong");
  property p_band;
    (cal_phase == scdc_pkg::SCDC_LEVEL && ph_q == scdc_pkg::SCDC_BAND) |->
      cnt_q == 32'd176 * 32'(cfg_q[27:20]);
  endproperty
  a_band: assert property (p_band) else $error("band length wrong");
  property p_level;
    (cal_phase == scdc_pkg::SCDC_IDLE && ph_q == scdc_pkg::SCDC_LEVEL) |->
      cnt_q == 32'd63 * (32'(cfg_q[9:5]) * 32'd1024 + lo);
  endproperty
  a_level: assert property (p_level) else $error("level length wrong");
  // The tick is registered, so it belongs to the phase of the cycle before.
  property p_tick;
    band_tick |-> ph_q == scdc_pkg::SCDC_BAND;
  endproperty
  a_tick: assert property (p_tick) else $error("tick outside band");
  property p_mode;
    wr_done && paddr == scdc_pkg::REG_REF_CFG |=> ref_differential == $past(pwdata[6]);
  endproperty
  a_mode: assert property (p_mode) else $error("reference mode wrong");
  property p_buf;
    $changed(primary_fraction) |-> $past(wr_done && paddr == scdc_pkg::REG_TRIGGER);
  endproperty
  a_buf: assert property (p_buf) else $error("fraction loaded early");
  property p_ratio;
    ref_divide_ratio >= 6'd1 && ref_divide_ratio <= 6'd32;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio out of range");
  property p_frac;
    fractional_mode == (primary_fraction != 25'h0 || auxiliary_fraction != 14'h0);
  endproperty
  a_frac: assert property (p_frac) else $error("mode flag wrong");
  c_start: cover property (cal_phase == scdc_pkg::SCDC_SETTLE && ph_q == 2'h0);
  c_band: cover property (cal_phase == scdc_pkg::SCDC_LEVEL && ph_q == 2'h2);
  c_done: cover property (cal_phase == scdc_pkg::SCDC_IDLE && ph_q == 2'h3);
endmodule : scdc_chk

bind scdc_top scdc_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .int_value, .primary_fraction, .auxiliary_fraction, .fractional_mode,
  .ref_divide_ratio, .ref_differential, .tune_hold, .band_tick, .cal_phase);

/* testbench.sv */
/*
  Self-checking bench for scdc_top: APB access, buffered settings, calibration.
  Assumes a 25 MHz pclk and scdc_chk bound beside the design.
*/
`timescale 1ns/1ps
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_s;
  logic        pready, pslverr, er_s;
  logic [15:0] int_value;
  logic [24:0] primary_fraction;
  logic [13:0] auxiliary_fraction, auxiliary_modulus;
  logic        fractional_mode, modulator_disable, ref_doubler, ref_halve;
  logic [5:0]  ref_divide_ratio;
  logic        ref_differential, tune_hold, band_tick;
  logic [1:0]  cal_phase;
  int          n_errors, checks_done, ticks, held;
  int          n[4];
  scdc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .int_value, .primary_fraction, .auxiliary_fraction,
    .auxiliary_modulus, .fractional_mode, .modulator_disable, .ref_divide_ratio,
    .ref_doubler, .ref_halve, .ref_differential, .tune_hold, .band_tick, .cal_phase);
  // Half period of 20 ns gives the 25 MHz clock.
  always #20 pclk = ~pclk;
  // ---------------------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd_s = prdata;
    er_s = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) chk(32'h0, 32'h1);
    @(negedge pclk);
  endtask : apb
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Watchdog, about four times the expected run.
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(ref_divide_ratio), 32'h1);
    chk(32'(auxiliary_modulus), 32'h2);
    apb(1'b0, scdc_pkg::REG_CAL_CFG, 32'h0);
    chk(rd_s, 32'h00100862);
    apb(1'b0, 8'h1C, 32'h0);
    chk({rd_s[30:0], er_s}, 32'h1);
    $display("reset test done");
    // Fraction and reference divider settings wait for the trigger; mode bits and the integer act at once.
    apb(1'b1, scdc_pkg::REG_PRIM_FRAC, 32'h01FFFFFF);
    apb(1'b1, scdc_pkg::REG_AUX_FRAC, 32'h3FFF002A);
    apb(1'b1, scdc_pkg::REG_REF_CFG, 32'h000003C0);
    // An integer part of 80 is legal in both integer and fractional mode.
    apb(1'b1, scdc_pkg::REG_INT_VALUE, 32'h00000050);
    chk(32'(primary_fraction), 32'h0);
    chk({ref_differential, modulator_disable, int_value}, 32'h30050);
    apb(1'b1, scdc_pkg::REG_TRIGGER, 32'h0);
    repeat (3) @(negedge pclk);
    chk(32'(primary_fraction), 32'h01FFFFFF);
    chk({auxiliary_modulus, auxiliary_fraction}, 32'hFFFC02A);
    chk({ref_doubler, ref_halve, ref_divide_ratio}, 32'hE0);
    chk({fractional_mode, cal_phase}, 32'h4);
    apb(1'b1, scdc_pkg::REG_PRIM_FRAC, 32'h0);
    apb(1'b1, scdc_pkg::REG_AUX_FRAC, 32'h00020000);
    apb(1'b1, scdc_pkg::REG_REF_CFG, 32'h5);
    apb(1'b1, scdc_pkg::REG_TRIGGER, 32'h0);
    repeat (3) @(negedge pclk);
    chk({fractional_mode, ref_differential, ref_divide_ratio}, 32'h5);
    $display("buffer test done");
    // Settle 2*1024+2, band divider 2, automatic start on. The level high count
    // stays at zero, below its legal floor, only to keep the 63 level steps short.
    apb(1'b1, scdc_pkg::REG_CAL_CFG, 32'h10200802);
    apb(1'b1, scdc_pkg::REG_TRIGGER, 32'h0);
    for (int i = 0; i < 4000; i++) begin
      @(posedge pclk);
      if (cal_phase === 2'b00 && n[1] > 0) break;
      if (cal_phase !== 2'b00) n[cal_phase]++;
      // The registered tick lags its band clock, so the last one shows in level.
      if (band_tick === 1'b1) ticks++;
      if (tune_hold === 1'b1) held++;
    end
    chk(32'(n[1]), 32'd2050);
    chk(32'(n[2]), 32'd352);
    chk(32'(ticks), 32'd176);
    chk(32'(n[3]), 32'd126);
    chk(32'(held), 32'd2528);
    apb(1'b0, scdc_pkg::REG_STATUS, 32'h0);
    chk({rd_s[2:0], tune_hold}, 32'h0);
    $display("calibration test done");
    // Legal counts throughout; a trigger in mid level calibration restarts settle.
    apb(1'b1, scdc_pkg::REG_CAL_CFG, 32'h10100842);
    apb(1'b1, scdc_pkg::REG_TRIGGER, 32'h0);
    for (int i = 0; i < 4000 && cal_phase !== 2'b11; i++) @(posedge pclk);
    apb(1'b0, scdc_pkg::REG_STATUS, 32'h0);
    chk(rd_s, 32'h00000007);
    apb(1'b1, scdc_pkg::REG_TRIGGER, 32'h0);
    chk({29'h0, tune_hold, cal_phase}, 32'h5);
    $display("restart test done");
    wrap_up();
  end
endmodule : testbench
